// [shared/cdp_params.svh]
// Purpose: Offsets, field positions, opcodes and reset values
// Assumes: Word-aligned APB register map
// Notes:   Definitions only
`ifndef CDP_PARAMS_SVH
`define CDP_PARAMS_SVH
// Register byte offsets
`define CDP_OFF_VR0      8'h00
`define CDP_OFF_STATUS   8'h24
`define CDP_OFF_MEMWORD  8'h28
`define CDP_OFF_CMD      8'h2C
`define CDP_OFF_IRQ_STAT 8'h30
`define CDP_OFF_IRQ_MASK 8'h34
`define CDP_NUM_VR       9
// Status fields
`define CDP_ST_SAT       0
`define CDP_ST_RND       1
`define CDP_ST_SHR_LO    2
`define CDP_ST_SHR_HI    6
`define CDP_ST_REAL_OVERFLOW_FLAG      8
`define CDP_ST_IMAG_OVERFLOW_FLAG      9
`define CDP_STATUS_RST   32'h0000_0000
// Interrupt bits
`define CDP_IRQ_REAL_OVERFLOW_FLAG     0
`define CDP_IRQ_IMAG_OVERFLOW_FLAG     1
`define CDP_IRQ_BAD      2
`define CDP_IRQ_W        3
// Opcodes
`define CDP_OPC_MUL      16'hE500
`define CDP_OPC_MULLD    16'hE3F6
`define CDP_OPC_NEG_HI   12'hE51
`define CDP_OPC_SUB      16'hE503
`define CDP_OPC_SUBLD    16'hE2CA
`define CDP_MSW_HI       4'h0
// Fixed register roles
`define CDP_VR_IMPROD    4'd2
`define CDP_VR_REPROD    4'd3
`define CDP_VR_IMMIN     4'd4
`define CDP_VR_REMIN     4'd5
`define CDP_VR_NINTH     4'd8
`define CDP_MAX_POS      32'h7FFF_FFFF
`define CDP_MIN_NEG      32'h8000_0000
`endif

// [shared/cdp_pkg.sv]
// Purpose: Types of the complex arithmetic datapath
// Assumes: Constants come from cdp_params.svh
// Notes:   Types only
package cdp_pkg;
   typedef logic [31:0] cdp_word_t;
   typedef enum logic [2:0] {
      CDP_NONE, CDP_MUL, CDP_MULLD, CDP_NEG, CDP_SUB, CDP_SUBLD, CDP_BAD
   } cdp_op_t;
endpackage

// [shared/cdp_lane_if.sv]
// Purpose: One subtract lane: operands, controls and result
// Assumes: Purely combinational lane
// Notes:   One instance per real and imaginary part
`timescale 1ns/10ps
interface cdp_lane_if;
   logic [31:0] minuend;
   logic [31:0] subtrahend;
   logic [4:0]  shift;
   logic        rnd;
   logic        sat;
   logic [31:0] result;
   logic        ovf;
   modport calc (input minuend, subtrahend, shift, rnd, sat, output result, ovf);
   modport user (output minuend, subtrahend, shift, rnd, sat, input result, ovf);
endinterface

// [core/cdp_sub_lane.sv]
// Purpose: Shifted, rounded, saturating 32-bit subtract lane
// Assumes: Shift of 0 to 31
// Notes:   Combinational
`timescale 1ns/10ps
`include "cdp_params.svh"
module cdp_sub_lane
(
   cdp_lane_if.calc l
);
   logic signed [32:0] half_w;
   logic signed [32:0] shifted_w;
   logic signed [33:0] diff_w;
   logic               range_w;

   // Half of the kept LSB weight, added before the bits drop out
   assign half_w    = (l.shift == 5'd0) ? 33'sd0
                    : $signed(33'd1 << (l.shift - 5'd1));
   assign shifted_w = ($signed({l.subtrahend[31], l.subtrahend})
                    + (l.rnd ? half_w : 33'sd0)) >>> l.shift;
   assign diff_w    = $signed({{2{l.minuend[31]}}, l.minuend})
                    - $signed({shifted_w[32], shifted_w});
   assign range_w   = (diff_w[33:31] != 3'b000) && (diff_w[33:31] != 3'b111);
   assign l.ovf     = range_w;
   assign l.result  = (range_w && l.sat)
                    ? (diff_w[33] ? `CDP_MIN_NEG : `CDP_MAX_POS)
                    : diff_w[31:0];
endmodule

// [core/cdp_top.sv]
// Purpose: Complex arithmetic datapath with APB register access
// Assumes: Host keeps issue spacing; illegal destinations are refused and flagged
// Notes:   Instructions are issued by writing the command register
`timescale 1ns/10ps
`include "cdp_params.svh"
module cdp_top
(
   // Clock and reset
   input  wire logic               clk_i,
   input  wire logic               rst_n_i,
   // APB slave
   input  wire logic               psel_i,
   input  wire logic               penable_i,
   input  wire logic               pwrite_i,
   input  wire logic [7:0]         paddr_i,
   input  wire cdp_pkg::cdp_word_t pwdata_i,
   output      cdp_pkg::cdp_word_t prdata_o,
   output      logic               pready_o,
   output      logic               pslverr_o,
   // Interrupt
   output      logic               irq_o
);
   import cdp_pkg::*;

   //**********************************************************
   // Reset release
   //**********************************************************
   logic rst_s1_q;
   logic rst_n_q;

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         rst_s1_q <= 1'b0;
         rst_n_q  <= 1'b0;
      end
      else
      begin
         rst_s1_q <= 1'b1;
         rst_n_q  <= rst_s1_q;
      end
   end

   //**********************************************************
   // State
   //**********************************************************
   cdp_word_t                vr_q [`CDP_NUM_VR];
   cdp_word_t                vr_d [`CDP_NUM_VR];
   logic                     sat_q;
   logic                     rnd_q;
   logic [4:0]               shr_q;
   logic                     real_overflow_flag_q;
   logic                     imag_overflow_flag_q;
   cdp_word_t                mem_q;
   logic [`CDP_IRQ_W-1:0]    ist_q;
   logic [`CDP_IRQ_W-1:0]    imask_q;
   logic signed [32:0]       mre_q;
   logic signed [32:0]       mim_q;
   logic                     mv_q;
   cdp_word_t                prdata_q;
   logic                     pready_q;
   logic                     pslverr_q;
   logic                     irq_q;
   // A literal cannot be indexed, so the status reset word gets a name
   localparam cdp_word_t     st_rst_c = `CDP_STATUS_RST;

   //**********************************************************
   // APB decode
   //**********************************************************
   wire        setup_w  = psel_i && !penable_i;
   wire        acc_w    = psel_i && penable_i && pready_q;
   wire        wr_w     = acc_w && pwrite_i;
   wire        rd_w     = acc_w && !pwrite_i;
   wire [5:0]  idx_w    = paddr_i[7:2];
   wire        is_vr_w  = (paddr_i[1:0] == 2'b00)
                       && (idx_w < 6'(`CDP_NUM_VR));
   wire        is_st_w  = paddr_i == `CDP_OFF_STATUS;
   wire        is_mem_w = paddr_i == `CDP_OFF_MEMWORD;
   wire        is_cmd_w = paddr_i == `CDP_OFF_CMD;
   wire        is_ist_w = paddr_i == `CDP_OFF_IRQ_STAT;
   wire        is_imk_w = paddr_i == `CDP_OFF_IRQ_MASK;
   wire        mapped_w = is_vr_w || is_st_w || is_mem_w || is_cmd_w
                       || is_ist_w || is_imk_w;
   wire [3:0]  vri_w    = idx_w[3:0];

   //**********************************************************
   // Instruction decode
   //**********************************************************
   wire        issue_w  = wr_w && is_cmd_w;
   wire [15:0] lsw_w    = pwdata_i[15:0];
   wire [15:0] msw_w    = pwdata_i[31:16];
   wire [3:0]  dst_w    = msw_w[11:8];
   wire [3:0]  nsel_w   = lsw_w[3:0];
   cdp_op_t    op_w;

   always_comb
   begin
      op_w = CDP_NONE;
      if (issue_w)
      begin
         if (lsw_w == `CDP_OPC_MUL)
            op_w = CDP_MUL;
         else if (lsw_w == `CDP_OPC_MULLD && msw_w[15:12] == `CDP_MSW_HI)
            op_w = CDP_MULLD;
         else if (lsw_w[15:4] == `CDP_OPC_NEG_HI)
            op_w = CDP_NEG;
         else if (lsw_w == `CDP_OPC_SUB)
            op_w = CDP_SUB;
         else if (lsw_w == `CDP_OPC_SUBLD && msw_w[15:12] == `CDP_MSW_HI)
            op_w = CDP_SUBLD;
         else
            op_w = CDP_BAD;
      end
   end

   // Destinations that would collide with the results are refused
   wire mld_ok_w  = (dst_w < `CDP_VR_NINTH) && (dst_w != `CDP_VR_IMPROD)
                 && (dst_w != `CDP_VR_REPROD);
   wire sld_ok_w  = (dst_w < `CDP_VR_NINTH) && (dst_w != `CDP_VR_IMMIN)
                 && (dst_w != `CDP_VR_REMIN);
   wire neg_ok_w  = nsel_w < `CDP_VR_NINTH;
   wire do_mul_w  = (op_w == CDP_MUL) || (op_w == CDP_MULLD && mld_ok_w);
   wire do_sub_w  = (op_w == CDP_SUB) || (op_w == CDP_SUBLD && sld_ok_w);
   wire do_neg_w  = (op_w == CDP_NEG) && neg_ok_w;
   wire do_ld_w   = (op_w == CDP_MULLD && mld_ok_w)
                 || (op_w == CDP_SUBLD && sld_ok_w);
   wire bad_w     = (op_w == CDP_BAD)
                 || (op_w == CDP_MULLD && !mld_ok_w)
                 || (op_w == CDP_SUBLD && !sld_ok_w)
                 || (op_w == CDP_NEG && !neg_ok_w);

   //**********************************************************
   // Complex multiply, first stage
   //**********************************************************
   wire signed [15:0] xr_w = vr_q[0][31:16];
   wire signed [15:0] xi_w = vr_q[0][15:0];
   wire signed [15:0] yr_w = vr_q[1][31:16];
   wire signed [15:0] yi_w = vr_q[1][15:0];
   wire signed [31:0] prr_w = xr_w * yr_w;
   wire signed [31:0] pii_w = xi_w * yi_w;
   wire signed [31:0] pri_w = xr_w * yi_w;
   wire signed [31:0] pir_w = xi_w * yr_w;

   // Products are summed in 33 bits so the second stage sees true range
   always_ff @(posedge clk_i or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         mre_q <= '0;
         mim_q <= '0;
         mv_q  <= 1'b0;
      end
      else
      begin
         mre_q <= 33'(prr_w) - 33'(pii_w);
         mim_q <= 33'(pri_w) + 33'(pir_w);
         mv_q  <= do_mul_w;
      end
   end

   //**********************************************************
   // Complex multiply, second stage
   //**********************************************************
   wire       movr_w = mv_q && (mre_q[32] != mre_q[31]);
   wire       movi_w = mv_q && (mim_q[32] != mim_q[31]);
   cdp_word_t mres_re_w;
   cdp_word_t mres_im_w;

   assign mres_re_w = (movr_w && sat_q)
                    ? (mre_q[32] ? `CDP_MIN_NEG : `CDP_MAX_POS)
                    : mre_q[31:0];
   assign mres_im_w = (movi_w && sat_q)
                    ? (mim_q[32] ? `CDP_MIN_NEG : `CDP_MAX_POS)
                    : mim_q[31:0];

   //**********************************************************
   // Negate
   //**********************************************************
   cdp_word_t nin_w;
   cdp_word_t nres_w;
   wire       nmin_w = nin_w == `CDP_MIN_NEG;

   assign nin_w  = vr_q[neg_ok_w ? nsel_w : 4'd0];
   assign nres_w = nmin_w ? (sat_q ? `CDP_MAX_POS : `CDP_MIN_NEG)
                 : 32'(-nin_w);
   wire   novf_w = do_neg_w && nmin_w;

   //**********************************************************
   // Complex subtract lanes
   //**********************************************************
   cdp_lane_if lane_re ();
   cdp_lane_if lane_im ();

   assign lane_re.minuend    = vr_q[`CDP_VR_REMIN];
   assign lane_re.subtrahend = vr_q[`CDP_VR_REPROD];
   assign lane_re.shift      = shr_q;
   assign lane_re.rnd        = rnd_q;
   assign lane_re.sat        = sat_q;
   assign lane_im.minuend    = vr_q[`CDP_VR_IMMIN];
   assign lane_im.subtrahend = vr_q[`CDP_VR_IMPROD];
   assign lane_im.shift      = shr_q;
   assign lane_im.rnd        = rnd_q;
   assign lane_im.sat        = sat_q;

   cdp_sub_lane u_lane_re
   (
      .l (lane_re)
   );

   cdp_sub_lane u_lane_im
   (
      .l (lane_im)
   );

   wire sovr_w = do_sub_w && lane_re.ovf;
   wire sovi_w = do_sub_w && lane_im.ovf;

   //**********************************************************
   // Register file next state
   //**********************************************************
   // Later sources win: bus write, multiply, subtract, negate, load
   always_comb
   begin
      for (int i = 0; i < `CDP_NUM_VR; i++)
      begin
         vr_d[i] = vr_q[i];
         if (wr_w && is_vr_w && vri_w == 4'(i))
            vr_d[i] = pwdata_i;
      end
      if (mv_q)
      begin
         vr_d[`CDP_VR_REPROD] = mres_re_w;
         vr_d[`CDP_VR_IMPROD] = mres_im_w;
      end
      if (do_sub_w)
      begin
         vr_d[`CDP_VR_REMIN] = lane_re.result;
         vr_d[`CDP_VR_IMMIN] = lane_im.result;
      end
      if (do_neg_w)
         vr_d[nsel_w] = nres_w;
      if (do_ld_w)
         vr_d[dst_w] = mem_q;
   end

   always_ff @(posedge clk_i or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         for (int i = 0; i < `CDP_NUM_VR; i++)
            vr_q[i] <= '0;
      end
      else
      begin
         for (int i = 0; i < `CDP_NUM_VR; i++)
            vr_q[i] <= vr_d[i];
      end
   end

   //**********************************************************
   // Status and sticky flags
   //**********************************************************
   wire set_r_w = movr_w || sovr_w || novf_w;
   wire set_i_w = movi_w || sovi_w;
   wire st_wr_w = wr_w && is_st_w;
   wire clr_r_w = st_wr_w && pwdata_i[`CDP_ST_REAL_OVERFLOW_FLAG];
   wire clr_i_w = st_wr_w && pwdata_i[`CDP_ST_IMAG_OVERFLOW_FLAG];

   always_ff @(posedge clk_i or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         sat_q  <= st_rst_c[`CDP_ST_SAT];
         rnd_q  <= st_rst_c[`CDP_ST_RND];
         shr_q  <= st_rst_c[`CDP_ST_SHR_HI:`CDP_ST_SHR_LO];
         real_overflow_flag_q <= 1'b0;
         imag_overflow_flag_q <= 1'b0;
         mem_q  <= '0;
      end
      else
      begin
         if (st_wr_w)
         begin
            sat_q <= pwdata_i[`CDP_ST_SAT];
            rnd_q <= pwdata_i[`CDP_ST_RND];
            shr_q <= pwdata_i[`CDP_ST_SHR_HI:`CDP_ST_SHR_LO];
         end
         // Set wins over a clear in the same cycle
         real_overflow_flag_q <= set_r_w || (real_overflow_flag_q && !clr_r_w);
         imag_overflow_flag_q <= set_i_w || (imag_overflow_flag_q && !clr_i_w);
         if (wr_w && is_mem_w)
            mem_q <= pwdata_i;
      end
   end

   //**********************************************************
   // Interrupts
   //**********************************************************
   logic [`CDP_IRQ_W-1:0] iev_w;
   logic [`CDP_IRQ_W-1:0] ist_d;

   assign iev_w = {bad_w, set_i_w, set_r_w};
   // A read clears only the bits captured at setup; an event landing
   // between setup and access would otherwise be lost unseen
   assign ist_d = iev_w | (ist_q & ~((rd_w && is_ist_w)
                ? prdata_q[`CDP_IRQ_W-1:0] : '0));

   always_ff @(posedge clk_i or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         ist_q   <= '0;
         imask_q <= '0;
         irq_q   <= 1'b0;
      end
      else
      begin
         ist_q <= ist_d;
         if (wr_w && is_imk_w)
            imask_q <= pwdata_i[`CDP_IRQ_W-1:0];
         irq_q <= |(ist_d & imask_q);
      end
   end

   //**********************************************************
   // APB read path and answer
   //**********************************************************
   cdp_word_t st_rd_w;
   cdp_word_t rd_mux_w;

   always_comb
   begin
      st_rd_w = '0;
      st_rd_w[`CDP_ST_SAT] = sat_q;
      st_rd_w[`CDP_ST_RND] = rnd_q;
      st_rd_w[`CDP_ST_SHR_HI:`CDP_ST_SHR_LO] = shr_q;
      st_rd_w[`CDP_ST_REAL_OVERFLOW_FLAG] = real_overflow_flag_q;
      st_rd_w[`CDP_ST_IMAG_OVERFLOW_FLAG] = imag_overflow_flag_q;
   end

   assign rd_mux_w = is_vr_w  ? vr_q[vri_w < `CDP_VR_NINTH + 4'd1 ? vri_w : 4'd0]
                   : is_st_w  ? st_rd_w
                   : is_mem_w ? mem_q
                   : is_ist_w ? 32'(ist_q)
                   : is_imk_w ? 32'(imask_q)
                   : 32'h0000_0000;

   // Data is captured in the setup cycle; pready rises for one access cycle
   always_ff @(posedge clk_i or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         prdata_q  <= '0;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end
      else
      begin
         pready_q  <= setup_w;
         pslverr_q <= setup_w && !mapped_w;
         if (setup_w && !pwrite_i)
            prdata_q <= rd_mux_w;
      end
   end

   assign prdata_o  = prdata_q;
   assign pready_o  = pready_q;
   assign pslverr_o = pslverr_q;
   assign irq_o     = irq_q;
endmodule

// [tb/cdp_checker.sv]
// Purpose: Port checks of the complex datapath
// Assumes: One access cycle per APB transfer
// Notes:   Bound to cdp_top after the module
`timescale 1ns/10ps
`include "cdp_params.svh"
module cdp_checker
(
   // Clock and reset
   input wire logic               clk_i,
   input wire logic               rst_n_i,
   // APB and interrupt
   input wire logic               psel_i,
   input wire logic               penable_i,
   input wire logic               pwrite_i,
   input wire logic [7:0]         paddr_i,
   input wire cdp_pkg::cdp_word_t pwdata_i,
   input wire cdp_pkg::cdp_word_t prdata_o,
   input wire logic               pready_o,
   input wire logic               pslverr_o,
   input wire logic               irq_o
);
   import cdp_pkg::*;
   wire        setup_w = psel_i && !penable_i;
   wire        unmap_w = (paddr_i > `CDP_OFF_IRQ_MASK) || (paddr_i[1:0] != 2'b00);
   wire        st_w    = pready_o && paddr_i == `CDP_OFF_STATUS;
   logic [1:0] seen_q;
   logic [1:0] seen_d;
   // Flags known set; only a write of ones may drop them
   assign seen_d = pwrite_i ? (seen_q & ~pwdata_i[9:8]) : prdata_o[9:8];
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         seen_q <= 2'h0;
      else if (st_w)
         seen_q <= seen_d;
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   property p_rst_quiet;
      $rose(rst_n_i) |-> !pready_o && !irq_o ##1 !irq_o;
   endproperty
   a_rst_quiet: assert property (p_rst_quiet) else $error("active after reset");
   property p_mapped;
      setup_w && !unmap_w |=> pready_o && !pslverr_o;
   endproperty
   a_mapped: assert property (p_mapped) else $error("mapped access wrong");
   property p_unmapped;
      setup_w && unmap_w |=> pready_o && pslverr_o;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
   property p_rdy_once;
      pready_o |=> !pready_o;
   endproperty
   a_rdy_once: assert property (p_rdy_once) else $error("ready too long");
   property p_rdy_access;
      pready_o |-> psel_i && penable_i && $past(setup_w);
   endproperty
   a_rdy_access: assert property (p_rdy_access) else $error("ready outside access");
   property p_unmap_rd0;
      pready_o && pslverr_o && !pwrite_i |-> prdata_o == 32'h0;
   endproperty
   a_unmap_rd0: assert property (p_unmap_rd0) else $error("refused read data");
   property p_irq_clear;
      pready_o && !pwrite_i && paddr_i == `CDP_OFF_IRQ_STAT |-> ##2 !irq_o;
   endproperty
   a_irq_clear: assert property (p_irq_clear) else $error("irq after clear");
   property p_flags_sticky;
      st_w && !pwrite_i |-> (prdata_o[9:8] & seen_q) == seen_q;
   endproperty
   a_flags_sticky: assert property (p_flags_sticky) else $error("flag dropped");
endmodule
bind cdp_top cdp_checker u_chk
(
   .clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
   .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
   .pready_o(pready_o), .pslverr_o(pslverr_o), .irq_o(irq_o)
);

// [tb/cdp_host.sv]
// Purpose: Host pipeline issuing commands over APB
// Assumes: Slave answers with pready; the bench watchdog ends a hang
// Notes:   Requests change only just after a rising edge
`timescale 1ns/10ps
`include "cdp_params.svh"
module cdp_host
(
   // Clock
   input  wire logic               clk_i,
   // APB master
   output      logic               psel_o,
   output      logic               penable_o,
   output      logic               pwrite_o,
   output      logic [7:0]         paddr_o,
   output      cdp_pkg::cdp_word_t pwdata_o,
   input  wire cdp_pkg::cdp_word_t prdata_i,
   input  wire logic               pready_i,
   input  wire logic               pslverr_i
);
   import cdp_pkg::*;
   initial
   begin
      psel_o    = 1'b0;
      penable_o = 1'b0;
      pwrite_o  = 1'b0;
      paddr_o   = 8'h00;
      pwdata_o  = 32'h0;
   end
   // Load destinations are chosen by the caller; refusals are sent on purpose
   task automatic xfer(input logic w, input logic [7:0] a, input cdp_word_t d,
                       output cdp_word_t r, output logic e);
      psel_o    <= 1'b1;
      penable_o <= 1'b0;
      pwrite_o  <= w;
      paddr_o   <= a;
      pwdata_o  <= d;
      @(posedge clk_i);
      penable_o <= 1'b1;
      @(posedge clk_i);
      while (pready_i !== 1'b1)
         @(posedge clk_i);
      r = prdata_i;
      e = pslverr_i;
      psel_o    <= 1'b0;
      penable_o <= 1'b0;
      // Stale data is not left on the bus
      pwdata_o  <= ~d;
      @(posedge clk_i);
      // Products land late, so the next request waits one more cycle
      if (w && a == `CDP_OFF_CMD && (d[15:0] == `CDP_OPC_MUL || d[15:0] == `CDP_OPC_MULLD))
         @(posedge clk_i);
   endtask
endmodule

// [tb/testbench.sv]
// Purpose: Self-checking bench of the complex datapath
// Assumes: All requests go through the host model
// Notes:   Table rows first, then loads, refusals, interrupt and reset
`timescale 1ns/10ps
`include "cdp_params.svh"
module testbench;
   import cdp_pkg::*;
   logic       clk_i = 1'b0;
   logic       rst_n = 1'b0;
   logic       psel;
   logic       penable;
   logic       pwrite;
   logic [7:0] paddr;
   cdp_word_t  pwdata;
   cdp_word_t  prdata;
   logic       pready;
   logic       pslverr;
   logic       irq;
   logic       err;
   cdp_word_t  rdv;
   logic [7:0] a1;
   logic [7:0] a2;
   int         errors = 0;
   int         compares = 0;
   // Status, x, y, command, first result, second result, flags
   cdp_word_t  rows [12][7] = '{
      '{32'h0, 32'h00040006, 32'h000C0009, 32'hE500, 32'hFFFFFFFA, 32'h6C, 32'h0},
      '{32'h1, 32'h80008000, 32'h80008000, 32'hE500, 32'h0, 32'h7FFFFFFF, 32'h2},
      '{32'h0, 32'h80008000, 32'h80008000, 32'hE500, 32'h0, 32'h80000000, 32'h2},
      '{32'h1, 32'h80000000, 32'h0, 32'hE510, 32'h7FFFFFFF, 32'h7FFFFFFF, 32'h1},
      '{32'h0, 32'h80000000, 32'h0, 32'hE510, 32'h80000000, 32'h80000000, 32'h1},
      '{32'h0, 32'h5, 32'h0, 32'hE510, 32'hFFFFFFFB, 32'hFFFFFFFB, 32'h0},
      '{32'hA, 32'hA, 32'h7, 32'hE503, 32'h8, 32'h8, 32'h0},
      '{32'h6, 32'h0, 32'hFFFFFFF9, 32'hE503, 32'h3, 32'h3, 32'h0},
      '{32'h4, 32'h0, 32'hFFFFFFF9, 32'hE503, 32'h4, 32'h4, 32'h0},
      '{32'h1, 32'h80000000, 32'h1, 32'hE503, 32'h80000000, 32'h80000000, 32'h3},
      '{32'h0, 32'h80000000, 32'h1, 32'hE503, 32'h7FFFFFFF, 32'h7FFFFFFF, 32'h3},
      '{32'h80000000, 32'h0, 32'h0, 32'hE503, 32'h0, 32'h0, 32'h3}};
   cdp_word_t  bad [3] = '{32'h0200E3F6, 32'h0000E518, 32'h0500E2CA};
   logic [7:0] bad_reg [3] = '{8'h08, 8'h20, 8'h14};
   always #2 clk_i = ~clk_i;
   cdp_top u_dut
   (
      .clk_i(clk_i), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .irq_o(irq)
   );
   cdp_host u_host
   (
      .clk_i(clk_i), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
      .paddr_o(paddr), .pwdata_o(pwdata), .prdata_i(prdata), .pready_i(pready),
      .pslverr_i(pslverr)
   );
   task automatic chk(input cdp_word_t got, input cdp_word_t exp);
      compares++;
      if (got !== exp)
      begin
         errors++;
         $display("[FAIL] %0t mismatch got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input cdp_word_t d);
      u_host.xfer(1'b1, a, d, rdv, err);
   endtask
   task automatic rd(input logic [7:0] a, input cdp_word_t exp);
      u_host.xfer(1'b0, a, 32'h0, rdv, err);
      chk(rdv, exp);
   endtask
   // The interrupt lags one cycle, so it is sampled mid-cycle
   task automatic irq_chk(input logic exp);
      @(negedge clk_i);
      chk({31'h0, irq}, {31'h0, exp});
      @(posedge clk_i);
   endtask
   task automatic print_verdict();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial
   begin
      repeat (2) @(posedge clk_i);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk_i);
      wr(`CDP_OFF_MEMWORD, 32'h12345678);
      for (int i = 0; i < 12; i++)
      begin
         wr(`CDP_OFF_STATUS, rows[i][0][31] ? (rows[i][0] & 32'h7F) : (rows[i][0] | 32'h300));
         for (int j = 0; j < 6; j++)
            wr(8'(4 * j), (j == 0 || j > 3) ? rows[i][1] : rows[i][2]);
         wr(`CDP_OFF_CMD, rows[i][3]);
         a1 = rows[i][3][7:0] == 8'h00 ? 8'h0C : rows[i][3][7:0] == 8'h03 ? 8'h14 : 8'h00;
         a2 = rows[i][3][7:0] == 8'h00 ? 8'h08 : rows[i][3][7:0] == 8'h03 ? 8'h10 : 8'h00;
         rd(a1, rows[i][4]);
         rd(a2, rows[i][5]);
         rd(`CDP_OFF_STATUS, (rows[i][0] & 32'h7F) | (rows[i][6] << 8));
         $display("row %0d done", i);
      end
      wr(8'h00, 32'h00040006);
      wr(8'h04, 32'h000C0009);
      wr(`CDP_OFF_CMD, 32'h0600E3F6);
      rd(8'h18, 32'h12345678);
      rd(8'h0C, 32'hFFFFFFFA);
      wr(`CDP_OFF_CMD, 32'h0100E2CA);
      rd(8'h04, 32'h12345678);
      rd(8'h14, 32'h6);
      rd(8'h10, 32'hFFFFFF94);
      $display("load test done");
      rd(`CDP_OFF_IRQ_STAT, 32'h3);
      for (int i = 0; i < 3; i++)
      begin
         wr(bad_reg[i], 32'hA5A50000);
         wr(`CDP_OFF_CMD, bad[i]);
         rd(bad_reg[i], 32'hA5A50000);
      end
      irq_chk(1'b0);
      wr(`CDP_OFF_IRQ_MASK, 32'h4);
      irq_chk(1'b1);
      rd(`CDP_OFF_IRQ_STAT, 32'h4);
      irq_chk(1'b0);
      rd(`CDP_OFF_IRQ_MASK, 32'h4);
      $display("refusal test done");
      u_host.xfer(1'b1, 8'h38, 32'hFFFFFFFF, rdv, err);
      chk({31'h0, err}, 32'h1);
      u_host.xfer(1'b0, 8'h38, 32'h0, rdv, err);
      chk(rdv, 32'h0);
      $display("unmapped test done");
      wr(`CDP_OFF_STATUS, 32'hB);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk_i);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk_i);
      rd(`CDP_OFF_STATUS, 32'h0);
      rd(8'h04, 32'h0);
      rd(`CDP_OFF_IRQ_MASK, 32'h0);
      $display("reset test done");
      print_verdict();
   end
   initial
   begin
      // The whole run needs well under a thousand cycles
      repeat (5000) @(posedge clk_i);
      errors++;
      $display("[FAIL] %0t watchdog expired", $time);
      print_verdict();
   end
endmodule
